/* eeprom_link_pkg.sv */
// Package: constants and carrier types for the two-wire serial memory slave
package eeprom_link_pkg;
  localparam int PAGE_COUNT = 128;
  localparam int PAGE_BYTES = 16;
  localparam int ADDR_BITS = 11;
  localparam int WORD_BITS = 8;
  localparam int PAGE_BITS = 3;
  localparam int OFS_BITS = 4;
  localparam logic [3:0] DEV_PATTERN = 4'hA;
  localparam int WR_CYCLE_NS = 5000000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int WR_CYCLE_CLKS = WR_CYCLE_NS / CLK_PERIOD_NS;
  localparam logic [2:0] SYNC_RESET = 3'h7;
  localparam logic [10:0] ADDR_RESET = 11'h000;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;

  // Sampled bus line pair
  typedef struct packed {
    logic clk_line;
    logic data_line;
  } bus_lines_t;

  // Protocol phases
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEVADDR = 3'b001,
    ST_WORDADDR = 3'b010,
    ST_WRDATA = 3'b011,
    ST_RDDATA = 3'b100,
    ST_RDACK = 3'b101
  } phase_t;
endpackage

/* eeprom_link.sv */
// Two-wire serial memory slave: bus protocol engine with storage array
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - 128 pages of 16 bytes, 11-bit address
// - Data changes only while clock low
// - Data change with clock high is framing
// - Start is data falling with clock high
// - Stop is data rising with clock high
// - Stop after read enters standby at once
// - Addresses and data move as 8-bit words
// - Acknowledge received word low on ninth clock
// - Standby at power-up and after stop done
// - Start, nine clocks, start, stop resets protocol
// - Device address top nibble is 1010
// - Next three bits select page, upper address
// - Address LSB high reads, low writes
// - Ignore bus and withhold acknowledge while writing
////////////////////////////////////////////////////////////////////////////////
module eeprom_link #(
  parameter int WR_CLKS = eeprom_link_pkg::WR_CYCLE_CLKS
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_b_out,
  output logic standby_out,
  output logic write_busy_out
);
  localparam int AW = eeprom_link_pkg::ADDR_BITS;
  localparam int WB = eeprom_link_pkg::WORD_BITS;
  localparam int OB = eeprom_link_pkg::OFS_BITS;
  // Storage array, one byte per word address
  logic [WB-1:0] mem_ff [eeprom_link_pkg::PAGE_COUNT*eeprom_link_pkg::PAGE_BYTES];
  // Page buffer for the pending nonvolatile write
  logic [WB-1:0] pbuf_ff [eeprom_link_pkg::PAGE_BYTES];
  logic [eeprom_link_pkg::PAGE_BYTES-1:0] pvalid_ff;

  logic [2:0] scl_sync_ff;
  logic [2:0] sda_sync_ff;
  eeprom_link_pkg::bus_lines_t lines_ff;
  eeprom_link_pkg::phase_t phase_ff;
  logic [3:0] bit_ff;
  logic [WB-1:0] shift_ff;
  logic [AW-1:0] addr_ff;
  logic [AW-1:0] waddr_ff;
  logic drive_low_ff;
  logic busy_ff;
  logic [31:0] wcnt_ff;
  logic standby_ff;
  logic rd_nack_ff;
  logic commit_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Three-stage filters; a change counts once stages two and three agree,
  // so a single-cycle glitch on the lines never forms a start or stop
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      scl_sync_ff <= eeprom_link_pkg::SYNC_RESET;
      sda_sync_ff <= eeprom_link_pkg::SYNC_RESET;
    end
    else
    begin
      scl_sync_ff <= {scl_sync_ff[1:0], scl_in};
      sda_sync_ff <= {sda_sync_ff[1:0], sda_in};
    end
  end

  wire scl_agree = (scl_sync_ff[1] == scl_sync_ff[2]);
  wire sda_agree = (sda_sync_ff[1] == sda_sync_ff[2]);
  wire scl_flt = scl_agree ? scl_sync_ff[2] : lines_ff.clk_line;
  wire sda_flt = sda_agree ? sda_sync_ff[2] : lines_ff.data_line;

  // Filtered line state
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      lines_ff <= '{clk_line: 1'b1, data_line: 1'b1};
    else
      lines_ff <= '{clk_line: scl_flt, data_line: sda_flt};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge and condition decode
  wire scl_rise = scl_flt && !lines_ff.clk_line;
  wire scl_fall = !scl_flt && lines_ff.clk_line;
  wire start_det = lines_ff.clk_line && scl_flt && lines_ff.data_line && !sda_flt;
  wire stop_det = lines_ff.clk_line && scl_flt && !lines_ff.data_line && sda_flt;
  // Data bits are only taken on a clock rise; high-time changes are framing
  wire take_bit = scl_rise && !start_det && !stop_det;
  wire word_done = take_bit && (bit_ff == eeprom_link_pkg::BIT_LAST);
  wire [WB-1:0] word_in = {shift_ff[WB-2:0], sda_flt};
  wire dev_match = (word_in[7:4] == eeprom_link_pkg::DEV_PATTERN);
  wire [AW-1:0] dev_addr = {word_in[3:1], addr_ff[7:0]};
  wire ack_slot_end = scl_fall && (bit_ff == eeprom_link_pkg::BIT_ACK);
  wire [AW-1:0] addr_inc = addr_ff + 11'h001;
  wire [AW-1:0] page_inc = {addr_ff[AW-1:OB], addr_ff[OB-1:0] + 4'h1};
  wire [WB-1:0] rd_byte = mem_ff[addr_ff];
  wire wr_done = busy_ff && (wcnt_ff == 32'(WR_CLKS - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Protocol state machine; a start restarts address framing unless a write is busy, which
  // is also how the start, nine clocks, start, stop resync recovers
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      phase_ff <= eeprom_link_pkg::ST_IDLE;
      bit_ff <= 4'h0;
      shift_ff <= 8'h00;
      addr_ff <= eeprom_link_pkg::ADDR_RESET;
      waddr_ff <= eeprom_link_pkg::ADDR_RESET;
      drive_low_ff <= 1'b0;
      rd_nack_ff <= 1'b0;
      commit_ff <= 1'b0;
      pvalid_ff <= '0;
    end
    else if (busy_ff)
    begin
      phase_ff <= eeprom_link_pkg::ST_IDLE;
      drive_low_ff <= 1'b0;
      commit_ff <= 1'b0;
      pvalid_ff <= '0;
    end
    else if (stop_det)
    begin
      phase_ff <= eeprom_link_pkg::ST_IDLE;
      drive_low_ff <= 1'b0;
      commit_ff <= (pvalid_ff != '0);
      bit_ff <= 4'h0;
    end
    else if (start_det)
    begin
      phase_ff <= eeprom_link_pkg::ST_DEVADDR;
      bit_ff <= 4'h0;
      drive_low_ff <= 1'b0;
      commit_ff <= 1'b0;
      pvalid_ff <= '0;
    end
    else
    begin
      commit_ff <= 1'b0;
      if (take_bit && bit_ff < eeprom_link_pkg::BIT_ACK)
      begin
        shift_ff <= word_in;
        bit_ff <= bit_ff + 4'h1;
      end
      if (take_bit && bit_ff == eeprom_link_pkg::BIT_ACK && phase_ff == eeprom_link_pkg::ST_RDACK)
        rd_nack_ff <= sda_flt;
      unique case (phase_ff)
        eeprom_link_pkg::ST_IDLE:
          drive_low_ff <= 1'b0;
        eeprom_link_pkg::ST_DEVADDR:
        begin
          if (word_done && !dev_match)
            phase_ff <= eeprom_link_pkg::ST_IDLE;
          else if (scl_fall && bit_ff == eeprom_link_pkg::BIT_ACK && !drive_low_ff)
            drive_low_ff <= 1'b1;
          else if (word_done)
            addr_ff <= dev_addr;
          else if (ack_slot_end)
          begin
            drive_low_ff <= 1'b0;
            bit_ff <= 4'h0;
            if (shift_ff[0])
            begin
              phase_ff <= eeprom_link_pkg::ST_RDDATA;
              drive_low_ff <= !rd_byte[7];
              shift_ff <= rd_byte;
            end
            else
              phase_ff <= eeprom_link_pkg::ST_WORDADDR;
          end
        end
        eeprom_link_pkg::ST_WORDADDR, eeprom_link_pkg::ST_WRDATA:
        begin
          if (scl_fall && bit_ff == eeprom_link_pkg::BIT_ACK && !drive_low_ff)
            drive_low_ff <= 1'b1;
          else if (ack_slot_end)
          begin
            drive_low_ff <= 1'b0;
            bit_ff <= 4'h0;
            if (phase_ff == eeprom_link_pkg::ST_WORDADDR)
            begin
              addr_ff <= {addr_ff[AW-1:8], shift_ff};
              waddr_ff <= {addr_ff[AW-1:8], shift_ff};
              phase_ff <= eeprom_link_pkg::ST_WRDATA;
            end
            else
            begin
              pbuf_ff[addr_ff[OB-1:0]] <= shift_ff;
              pvalid_ff[addr_ff[OB-1:0]] <= 1'b1;
              addr_ff <= page_inc; // Write rolls within the page
            end
          end
        end
        eeprom_link_pkg::ST_RDDATA:
        begin
          // Shift out on clock fall; bit 8 releases for the master's answer
          if (scl_fall)
          begin
            if (bit_ff == eeprom_link_pkg::BIT_ACK)
            begin
              drive_low_ff <= 1'b0;
              phase_ff <= eeprom_link_pkg::ST_RDACK;
              addr_ff <= addr_inc;
            end
            else
              drive_low_ff <= !shift_ff[7];
          end
        end
        eeprom_link_pkg::ST_RDACK:
        begin
          if (scl_fall)
          begin
            bit_ff <= 4'h0;
            if (rd_nack_ff)
              phase_ff <= eeprom_link_pkg::ST_IDLE;
            else
            begin
              phase_ff <= eeprom_link_pkg::ST_RDDATA;
              shift_ff <= rd_byte;
              drive_low_ff <= !rd_byte[7];
            end
          end
        end
        default:
          phase_ff <= eeprom_link_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Self-timed write: stop commits the page buffer, then the bus is deaf
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      busy_ff <= 1'b0;
      wcnt_ff <= 32'h0000_0000;
    end
    else if (commit_ff)
    begin
      busy_ff <= 1'b1;
      wcnt_ff <= 32'h0000_0000;
    end
    else if (busy_ff)
    begin
      wcnt_ff <= wcnt_ff + 32'h0000_0001;
      if (wr_done)
        busy_ff <= 1'b0;
    end
  end

  // Array update at commit; kept byte-wise so partial pages are honoured
  always_ff @(posedge clk_in)
  begin
    if (commit_ff)
    begin
      for (int i = 0; i < eeprom_link_pkg::PAGE_BYTES; i++)
      begin
        if (pvalid_ff[i])
          mem_ff[{waddr_ff[AW-1:OB], 4'(i)}] <= pbuf_ff[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Standby: set at power-up, after stop once idle and no write pending
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      standby_ff <= 1'b1;
    else if (start_det && !busy_ff)
      standby_ff <= 1'b0;
    else if (stop_det && !busy_ff && pvalid_ff == '0)
      standby_ff <= 1'b1;
    else if (wr_done)
      standby_ff <= 1'b1;
  end

  // Open-drain pin: output always low, enable low only when pulling
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      sda_out <= 1'b0;
      sda_oe_b_out <= 1'b1;
      standby_out <= 1'b1;
      write_busy_out <= 1'b0;
    end
    else
    begin
      sda_out <= 1'b0;
      sda_oe_b_out <= !drive_low_ff;
      standby_out <= standby_ff;
      write_busy_out <= busy_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_ack_on_ninth: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (phase_ff == eeprom_link_pkg::ST_WRDATA && drive_low_ff && !$past(drive_low_ff))
    |-> bit_ff == eeprom_link_pkg::BIT_ACK)
    else $error("acknowledge outside ninth clock");
  a_busy_deaf_bus: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    busy_ff |=> !drive_low_ff)
    else $error("pulled data while write busy");
  a_pin_low_only: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !sda_out)
    else $error("data pin driven high");
  a_start_restarts: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (start_det && !busy_ff && !stop_det) |=> phase_ff == eeprom_link_pkg::ST_DEVADDR
    && bit_ff == 4'h0)
    else $error("start not seen");
  a_stop_idles: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (stop_det && !busy_ff) |=> phase_ff == eeprom_link_pkg::ST_IDLE)
    else $error("stop not seen");
  a_read_stop_standby: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (stop_det && !busy_ff && pvalid_ff == '0) |=> ##1 standby_out)
    else $error("no standby after read stop");
  a_bad_device_idle: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (phase_ff == eeprom_link_pkg::ST_DEVADDR && word_done && !dev_match && !busy_ff
    && !stop_det && !start_det) |=> phase_ff == eeprom_link_pkg::ST_IDLE)
    else $error("foreign address accepted");
  a_write_time: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $rose(busy_ff) |-> busy_ff [*8])
    else $error("write cycle too short");
  a_filter_hold: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !scl_agree |=> lines_ff.clk_line == $past(lines_ff.clk_line))
    else $error("clock moved before filter agreed");
endmodule

/* eeprom_bus_master.sv */
// Behavioural two-wire bus master that drives the serial memory slave
`timescale 1ns/1ps
module eeprom_bus_master (
  output logic scl_out,
  output logic sda_out,
  input wire logic sda_in
);
  // A quarter of a 64 ns bus clock period
  localparam time QTR = 16ns;

  ////////////////////////////////////////////////////////////////////////////////
  // Idle bus: clock stands high, data released to the pull-up
  initial
  begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  // One bit: data moves in mid-low, sampled in mid-high
  task automatic xfer_bit(input logic b, output logic s);
    #QTR sda_out = b;
    #QTR scl_out = 1'b1;
    #QTR s = sda_in;
    #QTR scl_out = 1'b0;
  endtask

  // Start works from idle and as a repeated start with clock low
  task automatic start_cond();
    #QTR sda_out = 1'b1;
    #QTR scl_out = 1'b1;
    #QTR sda_out = 1'b0;
    #QTR scl_out = 1'b0;
  endtask

  // Stop leaves the clock standing high between frames
  task automatic stop_cond();
    #QTR sda_out = 1'b0;
    #QTR scl_out = 1'b1;
    #QTR sda_out = 1'b1;
    #QTR;
  endtask

  // Byte out MSB first, the ninth clock carries the slave's answer
  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      xfer_bit(b[i], s);
    xfer_bit(1'b1, ack);
  endtask

  // Byte in with the line released, then our own acknowledge bit
  task automatic read_byte(input logic ack_bit, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      xfer_bit(1'b1, d[i]);
    xfer_bit(ack_bit, s);
  endtask

  // Resynchronising sequence after an interrupted transfer
  task automatic proto_reset();
    logic s;
    start_cond();
    repeat (9) xfer_bit(1'b1, s);
    start_cond();
    stop_cond();
  endtask
endmodule

/* tb_eeprom_link.sv */
// Self-checking testbench for the two-wire serial memory slave
`timescale 1ns/1ps
module tb_eeprom_link;
  // Short write cycle keeps the run brief
  localparam int WR_TEST = 400;
  logic clk_in;
  logic rst_b_in;
  logic scl_line;
  logic sda_drive;
  logic sda_out;
  logic sda_oe_b_out;
  logic standby_out;
  logic write_busy_out;
  logic ack;
  logic [7:0] rd;
  wire logic sda_wire;
  int miscompares;
  int n_tests;
  int busy_cnt;

  ////////////////////////////////////////////////////////////////////////////////
  // Wired-AND data line with pull-up: released parties read high
  assign sda_wire = sda_drive & (sda_oe_b_out | sda_out);

  eeprom_link #(.WR_CLKS(WR_TEST)) u_eeprom_link (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .scl_in(scl_line), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe_b_out(sda_oe_b_out), .standby_out(standby_out),
    .write_busy_out(write_busy_out));

  eeprom_bus_master u_eeprom_bus_master (
    .scl_out(scl_line), .sda_out(sda_drive), .sda_in(sda_wire));

  // 200 MHz system clock
  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  // Length of the self-timed write, counted by the bench itself
  always @(posedge clk_in)
    if (write_busy_out === 1'b1)
      busy_cnt++;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check_bit(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("tests %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Device address word: fixed pattern, page bits, direction
  function automatic logic [7:0] dev_word(input logic [2:0] page, input logic rd_bit);
    return {eeprom_link_pkg::DEV_PATTERN, page, rd_bit};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check_bit("standby at power-up", 1'b1, standby_out);
    check_bit("busy at power-up", 1'b0, write_busy_out);
    check_bit("line released", 1'b1, sda_oe_b_out);
    check_bit("pin level", 1'b0, sda_out);
  endtask

  // Three bytes from the last page offset: the later ones wrap to the page start
  task automatic t_write();
    u_eeprom_bus_master.start_cond();
    u_eeprom_bus_master.write_byte(dev_word(3'h3, 1'b0), ack);
    check_bit("devaddr ack", 1'b0, ack);
    u_eeprom_bus_master.write_byte(8'h2F, ack);
    check_bit("word addr ack", 1'b0, ack);
    u_eeprom_bus_master.write_byte(8'h5A, ack);
    check_bit("data ack", 1'b0, ack);
    u_eeprom_bus_master.write_byte(8'hC3, ack);
    check_bit("wrap data ack", 1'b0, ack);
    u_eeprom_bus_master.write_byte(8'h96, ack);
    check_bit("second wrap ack", 1'b0, ack);
    busy_cnt = 0;
    u_eeprom_bus_master.stop_cond();
    for (int i = 0; i < 10 && write_busy_out !== 1'b1; i++) @(negedge clk_in);
    check_bit("write cycle begun", 1'b1, write_busy_out);
    u_eeprom_bus_master.start_cond();
    u_eeprom_bus_master.write_byte(dev_word(3'h3, 1'b0), ack);
    check_bit("poll refused", 1'b1, ack);
    u_eeprom_bus_master.stop_cond();
    check_bit("still busy", 1'b1, write_busy_out);
    for (int i = 0; i < 600 && write_busy_out !== 1'b0; i++) @(negedge clk_in);
    check_bit("write length", 1'b1, busy_cnt >= WR_TEST - 2 && busy_cnt <= WR_TEST + 2);
    repeat (3) @(negedge clk_in);
    check_bit("standby after write", 1'b1, standby_out);
  endtask

  // Random read: dummy write of the address, repeated start, one byte, NACK, stop
  task automatic t_read(input logic [7:0] low, input logic [7:0] exp);
    u_eeprom_bus_master.start_cond();
    u_eeprom_bus_master.write_byte(dev_word(3'h3, 1'b0), ack);
    u_eeprom_bus_master.write_byte(low, ack);
    u_eeprom_bus_master.start_cond();
    u_eeprom_bus_master.write_byte(dev_word(3'h3, 1'b1), ack);
    check_bit("read devaddr ack", 1'b0, ack);
    u_eeprom_bus_master.read_byte(1'b1, rd);
    u_eeprom_bus_master.stop_cond();
    check_byte("read data", exp, rd);
    repeat (10) @(negedge clk_in);
    check_bit("standby after read", 1'b1, standby_out);
    check_bit("no write after read", 1'b0, write_busy_out);
  endtask

  // Sequential read: the master acknowledges, so the address steps to the next byte
  task automatic t_seq_read();
    u_eeprom_bus_master.start_cond();
    u_eeprom_bus_master.write_byte(dev_word(3'h3, 1'b0), ack);
    u_eeprom_bus_master.write_byte(8'h20, ack);
    u_eeprom_bus_master.start_cond();
    u_eeprom_bus_master.write_byte(dev_word(3'h3, 1'b1), ack);
    u_eeprom_bus_master.read_byte(1'b0, rd);
    check_byte("first of sequence", 8'hC3, rd);
    u_eeprom_bus_master.read_byte(1'b1, rd);
    u_eeprom_bus_master.stop_cond();
    check_byte("next in sequence", 8'h96, rd);
  endtask

  // Wrong pattern and bits without a start are both ignored
  task automatic t_refused();
    u_eeprom_bus_master.start_cond();
    u_eeprom_bus_master.write_byte({4'h5, 3'h3, 1'b0}, ack);
    check_bit("bad pattern", 1'b1, ack);
    u_eeprom_bus_master.stop_cond();
    @(negedge clk_in);
    u_eeprom_bus_master.write_byte(dev_word(3'h3, 1'b0), ack);
    check_bit("no start", 1'b1, ack);
    u_eeprom_bus_master.stop_cond();
  endtask

  // Transfer broken after three bits, then the resynchronising sequence
  task automatic t_resync();
    logic s;
    u_eeprom_bus_master.start_cond();
    repeat (3) u_eeprom_bus_master.xfer_bit(1'b1, s);
    u_eeprom_bus_master.proto_reset();
    repeat (10) @(negedge clk_in);
    t_read(8'h20, 8'hC3);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    miscompares = 0;
    n_tests = 0;
    busy_cnt = 0;
    rst_b_in = 1'b0;
    repeat (2) @(negedge clk_in);
    rst_b_in = 1'b1;
    repeat (10) @(negedge clk_in);
    t_reset();
    t_write();
    t_read(8'h2F, 8'h5A);
    t_read(8'h20, 8'hC3);
    t_seq_read();
    t_refused();
    t_resync();
    conclude();
  end

  // Watchdog: the tests need well under 30 us
  initial
  begin
    #100us;
    miscompares++;
    conclude();
  end
endmodule
